// File: common/flash_consts.svh
`ifndef FLASH_CONSTS_SVH
`define FLASH_CONSTS_SVH
// Summary of operation
// - page erase sets all 1-KB page bits
// - program one word, only ones to zeros
// - protection per 2-KB block, two bits
// - reload is cycles per microsecond minus one
// - reload resets to max-rate value
// - program-enable zero refuses changes
// - read-enable zero allows fetch only
// - blocked data read returns bus fault
// - blocked change sets access violation
// - delivered blocks fully open
// - protection only clears; uncommitted reverts
// - commit stores protection permanently
// - program or erase end sets done
// - raw shows events, masked shows enabled
// - write one clears status, zero ignored
// - debug port open only for code 0x2
// - debug change next power-up, permanent
// - debug disable spares the TAP
// - alias base+offset*32+bit*4, atomic
// - address bit zero selects commit target
// - debug commit needs address 0x900 first
// - key plus op bit starts, bit polls
// - flash accesses held off while busy

// ==========================================================
// register byte offsets
`define OFS_TARGET_ADDR 12'h000
`define OFS_DATA 12'h004
`define OFS_CONTROL 12'h008
`define OFS_RAW_STATUS 12'h00C
`define OFS_IRQ_MASK 12'h010
`define OFS_STATUS_CLEAR 12'h014
`define OFS_READ_PROT 12'h130
`define OFS_PROG_PROT 12'h134
`define OFS_US_RELOAD 12'h140

// ==========================================================
// field positions and codes
`define CTL_WRITE 0
`define CTL_ERASE 1
`define CTL_MERASE 2
`define CTL_COMMIT 3
`define WRITE_KEY 16'hA442
`define ST_ACCESS 0
`define ST_PROG 1
`define DBG_HI 31
`define DBG_LO 30
`define DBG_ENABLED 2'h2
`define DBG_COMMIT_ADDR 32'h0000_0900

// ==========================================================
// reset values and timing (microseconds)
`define READ_PROT_RST 32'h8000_000F
`define PROG_PROT_RST 32'h0000_000F
`define US_RELOAD_RST 8'h13
`define PROG_TIME_US 12'd20
`define ERASE_TIME_US 12'd200
`define COMMIT_TIME_US 12'd50
`endif

// File: common/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
  // operation sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_LOAD = 6'h01,
    ST_IDLE = 6'h02,
    ST_PROG_RD = 6'h04,
    ST_PROG_WR = 6'h08,
    ST_ERASE = 6'h10,
    ST_WAIT = 6'h20
  } op_state_e;

  typedef logic [31:0] word_t;

  // bit-band alias: base + byte offset * 32 + bit * 4
  function automatic word_t bitband_alias(input word_t base, input logic [19:0] ofs, input logic [2:0] bitn);
    bitband_alias = base + {7'h00, ofs, 5'h00} + {27'h0, bitn, 2'h0};
  endfunction : bitband_alias
endpackage : flash_ctrl_pkg

// File: logic/flash_array_mem.sv
// word array with one port; read data leave a register
module flash_array_mem #(
  parameter int AW = 11,
  parameter int DW = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // access port
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1]; // cell array, no reset
  logic [DW-1:0] rdata_reg;
  logic [DW-1:0] rdata_next;

  // ==========================================================
  // read path
  // read-before-write keeps the old word for merging
  always_comb begin
    rdata_next = mem[addr];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // write path, array cells carry no reset
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = rdata_reg;
endmodule : flash_array_mem

// File: logic/flash_protect_program_ctrl.sv
`include "flash_consts.svh"
module flash_protect_program_ctrl #(
  parameter int AW = 11,
  parameter int NB = 4,
  parameter logic [11:0] PROG_US = `PROG_TIME_US,
  parameter logic [11:0] ERASE_US = `ERASE_TIME_US,
  parameter logic [11:0] COMMIT_US = `COMMIT_TIME_US
) (
  // clock and resets
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic nv_rst_n,
  // axi4-lite write
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire flash_ctrl_pkg::word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output flash_ctrl_pkg::word_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core flash read and fetch port
  input wire logic mem_req,
  input wire logic [AW-1:0] mem_addr,
  input wire logic mem_ifetch,
  output logic mem_ready,
  output logic mem_rvalid,
  output flash_ctrl_pkg::word_t mem_rdata,
  output logic mem_fault,
  // bit-band alias
  input wire logic [19:0] alias_byte_offset,
  input wire logic [2:0] alias_bit,
  output flash_ctrl_pkg::word_t alias_addr,
  // status outputs
  output logic flash_irq,
  output logic debug_access_port_enable
);
  import flash_ctrl_pkg::*;

  localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000; // alias window
  localparam int PW = AW - 8; // page index bits

  // ==========================================================
  // state
  op_state_e state_reg, state_next;
  word_t target_addr_reg, target_addr_next; // flash_target_address
  word_t data_reg, data_next;
  logic [3:0] op_reg, op_next; // active op bits of flash_control
  logic [1:0] raw_reg, raw_next; // flash_raw_irq_status
  logic [1:0] mask_reg, mask_next; // flash_irq_mask
  word_t read_prot_reg, read_prot_next; // read_enable_protection
  word_t prog_prot_reg, prog_prot_next; // program_enable_protection
  word_t nv_read_reg, nv_read_next; // committed copies
  word_t nv_prog_reg, nv_prog_next;
  logic [7:0] reload_reg, reload_next; // microsecond_reload
  logic dap_en_reg, dap_en_next;
  logic [AW-1:0] cnt_reg, cnt_next; // erase word pointer
  logic [11:0] us_reg, us_next; // microseconds left
  logic aw_have_reg, aw_have_next;
  logic [11:0] awaddr_reg, awaddr_next;
  logic w_have_reg, w_have_next;
  word_t wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  word_t rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic rd_pend_reg, rd_pend_next; // core read answer due
  logic rd_fault_reg, rd_fault_next;
  word_t alias_reg, alias_next;

  // memory port and timer wiring
  logic arr_we;
  logic [AW-1:0] arr_addr;
  word_t arr_wdata;
  word_t arr_rdata;
  logic us_tick;

  // decode helpers
  logic do_write;
  word_t wmask;
  logic [1:0] blk;
  logic [1:0] set_ev;
  logic [1:0] clr_ev;

  flash_array_mem #(.AW(AW), .DW(32)) u_array (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .we(arr_we),
    .addr(arr_addr),
    .wdata(arr_wdata),
    .rdata(arr_rdata)
  );

  us_tick_gen #(.RW(8)) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(state_reg == ST_WAIT),
    .reload(reload_reg),
    .tick(us_tick)
  );

  // ==========================================================
  // combinational outputs
  assign s_axi_awready = !aw_have_reg;
  assign s_axi_wready = !w_have_reg;
  assign s_axi_arready = !rvalid_reg;
  assign mem_ready = state_reg == ST_IDLE;
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;
  assign blk = target_addr_reg[12:11];
  assign flash_irq = |(raw_reg & mask_reg);
  assign mem_rdata = rd_fault_reg ? '0 : arr_rdata;

  // byte strobes widened to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{wstrb_reg[i]}};
    end
  end

  // ==========================================================
  // array port: sequencer in ST_PROG_RD, ST_PROG_WR and ST_ERASE, else core
  always_comb begin
    arr_we = 1'b0;
    arr_addr = mem_addr;
    arr_wdata = '1;
    if (state_reg == ST_PROG_RD) begin
      arr_addr = target_addr_reg[AW+1:2];
    end else if (state_reg == ST_PROG_WR) begin
      arr_we = 1'b1;
      arr_addr = target_addr_reg[AW+1:2];
      arr_wdata = arr_rdata & data_reg;
    end else if (state_reg == ST_ERASE) begin
      arr_we = 1'b1;
      arr_addr = cnt_reg;
      arr_wdata = '1;
    end
  end

  // ==========================================================
  // register file, sequencer and bus slave next state
  always_comb begin
    state_next = state_reg;
    target_addr_next = target_addr_reg;
    data_next = data_reg;
    op_next = op_reg;
    mask_next = mask_reg;
    read_prot_next = read_prot_reg;
    prog_prot_next = prog_prot_reg;
    nv_read_next = nv_read_reg;
    nv_prog_next = nv_prog_reg;
    reload_next = reload_reg;
    dap_en_next = dap_en_reg;
    cnt_next = cnt_reg;
    us_next = us_reg;
    aw_have_next = aw_have_reg;
    awaddr_next = awaddr_reg;
    w_have_next = w_have_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    set_ev = 2'b00;
    clr_ev = 2'b00;
    // core read: fault decided at the request edge
    rd_pend_next = mem_req && mem_ready;
    rd_fault_next = mem_req && mem_ready && !mem_ifetch && !read_prot_reg[mem_addr[AW-1:AW-2]];
    // one alias word reaches one bit
    alias_next = bitband_alias(SRAM_ALIAS_BASE, alias_byte_offset, alias_bit);

    // write address and data taken in either order
    if (s_axi_awvalid && !aw_have_reg) begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_reg) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
    end

    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = 2'b00;
      case ({awaddr_reg[11:2], 2'b00})
        `OFS_TARGET_ADDR: target_addr_next = (target_addr_reg & ~wmask) | (wdata_reg & wmask);
        `OFS_DATA: data_next = (data_reg & ~wmask) | (wdata_reg & wmask);
        `OFS_IRQ_MASK: mask_next = (mask_reg & ~wmask[1:0]) | (wdata_reg[1:0] & wmask[1:0]);
        `OFS_STATUS_CLEAR: clr_ev = wdata_reg[1:0] & wmask[1:0];
        `OFS_READ_PROT: read_prot_next = read_prot_reg & (wdata_reg | ~wmask);
        `OFS_PROG_PROT: prog_prot_next = prog_prot_reg & (wdata_reg | ~wmask);
        `OFS_US_RELOAD: begin
          if (wstrb_reg[0]) begin
            reload_next = wdata_reg[7:0];
          end
        end
        `OFS_CONTROL: begin
          // full word with key; ignored while an op runs
          if (state_reg == ST_IDLE && &wstrb_reg && wdata_reg[31:16] == `WRITE_KEY) begin
            if (wdata_reg[`CTL_WRITE] || wdata_reg[`CTL_ERASE]) begin
              if (!prog_prot_reg[blk]) begin
                set_ev[`ST_ACCESS] = 1'b1;
              end else if (wdata_reg[`CTL_WRITE]) begin
                op_next = 4'b0001;
                state_next = ST_PROG_RD;
              end else begin
                op_next = 4'b0010;
                cnt_next = {target_addr_reg[AW+1:10], 8'h00};
                state_next = ST_ERASE;
              end
            end else if (wdata_reg[`CTL_MERASE]) begin
              // refused whole if any block is protected
              if (~|(~prog_prot_reg[NB-1:0])) begin
                op_next = 4'b0100;
                cnt_next = '0;
                state_next = ST_ERASE;
              end else begin
                set_ev[`ST_ACCESS] = 1'b1;
              end
            end else if (wdata_reg[`CTL_COMMIT]) begin
              op_next = 4'b1000;
              us_next = COMMIT_US;
              state_next = ST_WAIT;
            end
          end
        end
        `OFS_RAW_STATUS: bresp_next = 2'b00;
        default: bresp_next = 2'b10;
      endcase
    end

    // reads answer one cycle after the address
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = 2'b00;
      case ({s_axi_araddr[11:2], 2'b00})
        `OFS_TARGET_ADDR: rdata_next = target_addr_reg;
        `OFS_DATA: rdata_next = data_reg;
        `OFS_CONTROL: rdata_next = {28'h0, op_reg};
        `OFS_RAW_STATUS: rdata_next = {30'h0, raw_reg};
        `OFS_IRQ_MASK: rdata_next = {30'h0, mask_reg};
        `OFS_STATUS_CLEAR: rdata_next = {30'h0, raw_reg & mask_reg};
        `OFS_READ_PROT: rdata_next = read_prot_reg;
        `OFS_PROG_PROT: rdata_next = prog_prot_reg;
        `OFS_US_RELOAD: rdata_next = {24'h0, reload_reg};
        default: begin
          rdata_next = '0;
          rresp_next = 2'b10;
        end
      endcase
    end

    // sequencer
    case (state_reg)
      ST_LOAD: begin
        // reload from committed store
        read_prot_next = nv_read_reg;
        prog_prot_next = nv_prog_reg;
        dap_en_next = nv_read_reg[`DBG_HI:`DBG_LO] == `DBG_ENABLED;
        state_next = ST_IDLE;
      end
      ST_IDLE: begin
      end
      ST_PROG_RD: state_next = ST_PROG_WR;
      ST_PROG_WR: begin
        us_next = PROG_US;
        state_next = ST_WAIT;
      end
      ST_ERASE: begin
        cnt_next = cnt_reg + 1'b1;
        if (op_reg[`CTL_MERASE] ? &cnt_reg : &cnt_reg[7:0]) begin
          us_next = ERASE_US;
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (us_tick) begin
          us_next = us_reg - 1'b1;
          if (us_reg == 12'h001) begin
            op_next = 4'b0000;
            state_next = ST_IDLE;
            if (op_reg[`CTL_COMMIT]) begin
              // store only ever loses ones
              if (target_addr_reg == `DBG_COMMIT_ADDR) begin
                nv_read_next = nv_read_reg & read_prot_reg;
              end else if (target_addr_reg[0]) begin
                nv_prog_next = nv_prog_reg & prog_prot_reg;
              end else begin
                nv_read_next = nv_read_reg & {2'b11, read_prot_reg[29:0]};
              end
            end else begin
              set_ev[`ST_PROG] = 1'b1;
            end
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase

    // a new event beats a clear in the same cycle
    raw_next = (raw_reg & ~clr_ev) | set_ev;
  end

  // ==========================================================
  // committed store, factory reset only
  always_ff @(posedge core_clk or negedge nv_rst_n) begin
    if (!nv_rst_n) begin
      nv_read_reg <= `READ_PROT_RST;
      nv_prog_reg <= `PROG_PROT_RST;
    end else begin
      nv_read_reg <= nv_read_next;
      nv_prog_reg <= nv_prog_next;
    end
  end

  // ==========================================================
  // controller registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_LOAD;
      target_addr_reg <= '0;
      data_reg <= '0;
      op_reg <= '0;
      raw_reg <= '0;
      mask_reg <= '0;
      read_prot_reg <= `READ_PROT_RST;
      prog_prot_reg <= `PROG_PROT_RST;
      reload_reg <= `US_RELOAD_RST;
      dap_en_reg <= 1'b0;
      cnt_reg <= '0;
      us_reg <= '0;
      aw_have_reg <= 1'b0;
      awaddr_reg <= '0;
      w_have_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= '0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= '0;
      rd_pend_reg <= 1'b0;
      rd_fault_reg <= 1'b0;
      alias_reg <= '0;
    end else begin
      state_reg <= state_next;
      target_addr_reg <= target_addr_next;
      data_reg <= data_next;
      op_reg <= op_next;
      raw_reg <= raw_next;
      mask_reg <= mask_next;
      read_prot_reg <= read_prot_next;
      prog_prot_reg <= prog_prot_next;
      reload_reg <= reload_next;
      dap_en_reg <= dap_en_next;
      cnt_reg <= cnt_next;
      us_reg <= us_next;
      aw_have_reg <= aw_have_next;
      awaddr_reg <= awaddr_next;
      w_have_reg <= w_have_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      rd_pend_reg <= rd_pend_next;
      rd_fault_reg <= rd_fault_next;
      alias_reg <= alias_next;
    end
  end

  // ==========================================================
  // registered outputs
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign mem_rvalid = rd_pend_reg;
  assign mem_fault = rd_fault_reg;
  assign alias_addr = alias_reg;
  // debug port only; tap untouched
  assign debug_access_port_enable = dap_en_reg;
endmodule : flash_protect_program_ctrl

// File: logic/us_tick_gen.sv
// one-cycle tick every reload+1 clocks while running
module us_tick_gen #(
  parameter int RW = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic run,
  input wire logic [RW-1:0] reload,
  output logic tick
);
  logic [RW-1:0] cnt_reg;
  logic [RW-1:0] cnt_next;

  // ==========================================================
  // down counter, restarted whenever idle
  always_comb begin
    if (!run || cnt_reg == '0) begin
      cnt_next = reload;
    end else begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // first microsecond is full since the counter preloads while idle; waits are exact
  assign tick = run && cnt_reg == '0;
endmodule : us_tick_gen

// File: tb/flash_core_model.sv
// ==========================================
// core bus model: one flash read per command
module flash_core_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // command from the bench
  input wire logic cmd_go,
  input wire logic [10:0] cmd_addr,
  input wire logic cmd_ifetch,
  // flash read port
  output logic mem_req,
  output logic [10:0] mem_addr,
  output logic mem_ifetch,
  input wire logic mem_ready,
  input wire logic mem_rvalid,
  input wire flash_ctrl_pkg::word_t mem_rdata,
  input wire logic mem_fault,
  // answer to the bench
  output logic rsp_done,
  output flash_ctrl_pkg::word_t rsp_data,
  output logic rsp_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_ctrl_pkg::*;
  // hold until ready; released lines flip
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      mem_addr <= 11'h000;
      mem_ifetch <= 1'b0;
      rsp_done <= 1'b0;
      rsp_data <= 32'h0;
      rsp_fault <= 1'b0;
    end else begin
      rsp_done <= mem_rvalid;
      if (mem_rvalid) begin
        rsp_data <= mem_rdata;
        rsp_fault <= mem_fault;
      end
      if (mem_req && mem_ready) begin
        mem_req <= 1'b0;
        mem_addr <= ~mem_addr;
        mem_ifetch <= ~mem_ifetch;
      end else if (cmd_go && !mem_req) begin
        mem_req <= 1'b1;
        mem_addr <= cmd_addr;
        mem_ifetch <= cmd_ifetch;
      end
    end
  end
endmodule : flash_core_model

// File: tb/flash_ctrl_assertions.sv
// ==========================================
// port checker
module flash_ctrl_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // core port
  input wire logic mem_req,
  input wire logic mem_ifetch,
  input wire logic mem_ready,
  input wire logic mem_rvalid,
  input wire flash_ctrl_pkg::word_t mem_rdata,
  input wire logic mem_fault,
  // bus answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire flash_ctrl_pkg::word_t s_axi_rdata,
  // alias and debug
  input wire logic [19:0] alias_byte_offset,
  input wire logic [2:0] alias_bit,
  input wire flash_ctrl_pkg::word_t alias_addr,
  input wire logic debug_access_port_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_ctrl_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  core_answer_a: assert property (mem_req && mem_ready |=> mem_rvalid)
    else $error("core read not answered");
  core_quiet_a: assert property (!(mem_req && mem_ready) |=> !mem_rvalid)
    else $error("core answer without request");
  fetch_clean_a: assert property (mem_req && mem_ready && mem_ifetch |=> !mem_fault)
    else $error("fault on instruction fetch");
  fault_zero_a: assert property (mem_fault |-> mem_rvalid && mem_rdata == 32'h0)
    else $error("fault without answer or with data");
  // skip the first edge after reset
  alias_sum_a: assert property ($past(rst_n) |->
    alias_addr == 32'h2200_0000 + {7'h00, $past(alias_byte_offset), 5'h00} + {27'h0, $past(alias_bit), 2'h0})
    else $error("alias address wrong");
  dap_frozen_a: assert property ($past(rst_n, 2) |-> $stable(debug_access_port_enable))
    else $error("debug enable changed without power-up");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : flash_ctrl_checker

bind flash_protect_program_ctrl flash_ctrl_checker u_chk (.*);

// File: tb/test_flash_protect_program_ctrl.sv
module test_flash_protect_program_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_ctrl_pkg::*;
  // ==========================================
  // signals
  logic core_clk = 1'b0, rst_n = 1'b0, nv_rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  word_t s_axi_wdata = 32'h0, s_axi_rdata, mem_rdata, alias_addr, rsp_data, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic mem_req, mem_ifetch, mem_ready, mem_rvalid, mem_fault, flash_irq, debug_access_port_enable;
  logic [10:0] mem_addr, cmd_addr = 11'h000;
  logic cmd_go = 1'b0, cmd_ifetch = 1'b0, rsp_done, rsp_fault;
  logic [19:0] alias_byte_offset = 20'h01000;
  logic [2:0] alias_bit = 3'h3;
  int num_errors = 0, compares = 0, cycles = 0;
  // short op times keep the run brief
  flash_protect_program_ctrl #(.PROG_US(12'h002), .ERASE_US(12'h002), .COMMIT_US(12'h002)) dut (.core_clk,
    .rst_n, .nv_rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mem_req, .mem_addr, .mem_ifetch, .mem_ready,
    .mem_rvalid, .mem_rdata, .mem_fault, .alias_byte_offset, .alias_bit, .alias_addr, .flash_irq,
    .debug_access_port_enable);
  flash_core_model core (.*);
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ==========================================
  // tasks
  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input word_t got, input word_t exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // aw and w offered together
  task automatic wr(input logic [11:0] a, input word_t d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rd
  task automatic poll(input int b);
    do rd(12'h008); while (rdv[b] !== 1'b0);
  endtask : poll
  task automatic core_rd(input logic [10:0] a, input logic f);
    @(posedge core_clk);
    cmd_go <= 1'b1;
    cmd_addr <= a;
    cmd_ifetch <= f;
    @(posedge core_clk);
    cmd_go <= 1'b0;
    do @(posedge core_clk); while (rsp_done !== 1'b1);
  endtask : core_rd
  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask : do_reset
  // ==========================================
  // scenarios
  task automatic t_reset_vals();
    rd(12'h130);
    chk(rdv, 32'h8000_000F);
    rd(12'h134);
    chk(rdv, 32'h0000_000F);
    rd(12'h140);
    chk(rdv, 32'h0000_0013);
    rd(12'h200);
    chk({30'h0, rsp}, 32'h2);
    wr(12'h200, 32'h0);
    chk({30'h0, rsp}, 32'h2);
    chk({31'h0, debug_access_port_enable}, 32'h1);
    chk(alias_addr, 32'h2200_0000 + 32'h1000 * 32 + 3 * 4);
  endtask : t_reset_vals
  task automatic t_erase();
    wr(12'h140, 32'h1);
    wr(12'h000, 32'h0);
    wr(12'h008, 32'hA442_0002);
    repeat (2) @(posedge core_clk);
    chk({31'h0, mem_ready}, 32'h0);
    poll(1);
    core_rd(11'h000, 1'b0);
    chk(rsp_data, 32'hFFFF_FFFF);
    core_rd(11'h0FF, 1'b0);
    chk(rsp_data, 32'hFFFF_FFFF);
    rd(12'h00C);
    chk(rdv, 32'h2);
    chk({31'h0, flash_irq}, 32'h0);
  endtask : t_erase
  task automatic t_program();
    wr(12'h004, 32'hA5A5_0F0F);
    wr(12'h008, 32'hA442_0001);
    poll(0);
    wr(12'h004, 32'hFFFF_00FF);
    wr(12'h008, 32'hA442_0001);
    poll(0);
    core_rd(11'h000, 1'b0);
    chk(rsp_data, 32'hA5A5_000F);
    wr(12'h010, 32'h3);
    chk({31'h0, flash_irq}, 32'h1);
    rd(12'h014);
    chk(rdv, 32'h2);
    wr(12'h014, 32'h0);
    rd(12'h00C);
    chk(rdv, 32'h2);
    wr(12'h014, 32'h2);
    rd(12'h00C);
    chk(rdv, 32'h0);
    chk({31'h0, flash_irq}, 32'h0);
  endtask : t_program
  task automatic t_protect();
    wr(12'h134, 32'hE);
    wr(12'h134, 32'hF);
    rd(12'h134);
    chk(rdv, 32'hE);
    wr(12'h008, 32'hA442_0002);
    rd(12'h00C);
    chk(rdv, 32'h1);
    chk({31'h0, flash_irq}, 32'h1);
    wr(12'h014, 32'h1);
    wr(12'h008, 32'hA442_0004);
    core_rd(11'h000, 1'b0);
    chk(rsp_data, 32'hA5A5_000F);
    wr(12'h130, 32'h8000_000D);
    core_rd(11'h200, 1'b0);
    chk({rsp_data[30:0], rsp_fault}, 32'h1);
    core_rd(11'h200, 1'b1);
    chk({31'h0, rsp_fault}, 32'h0);
    core_rd(11'h000, 1'b0);
    chk({31'h0, rsp_fault}, 32'h0);
  endtask : t_protect
  task automatic t_commit();
    do_reset();
    rd(12'h134);
    chk(rdv, 32'hF);
    wr(12'h134, 32'hE);
    wr(12'h000, 32'h1);
    wr(12'h008, 32'hA442_0008);
    poll(3);
    do_reset();
    rd(12'h134);
    chk(rdv, 32'hE);
    rd(12'h130);
    chk(rdv, 32'h8000_000F);
    wr(12'h130, 32'h0000_000F);
    wr(12'h000, 32'h900);
    wr(12'h008, 32'hA442_0008);
    poll(3);
    chk({31'h0, debug_access_port_enable}, 32'h1);
    do_reset();
    chk({31'h0, debug_access_port_enable}, 32'h0);
    wr(12'h130, 32'hC000_000F);
    rd(12'h130);
    chk(rdv, 32'h0000_000F);
  endtask : t_commit
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    nv_rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset_vals();
    t_erase();
    t_program();
    t_protect();
    t_commit();
    report_and_stop();
  end
endmodule : test_flash_protect_program_ctrl
